//--- hdl/duc_top.sv
// Dual serial channel block behind an asynchronous eight-bit host bus.
`timescale 1ns/10ps
`default_nettype none
module duc_top
  import duc_pkg::*;
#(
  parameter int DIV_W = DUC_DIV_W,
  parameter int DEPTH = DUC_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Host bus.
  input wire logic cs_n,
  input wire logic channel_select,
  input wire logic [2:0] addr,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Serial lines, index 0 is channel A and index 1 channel B.
  input wire logic [1:0] rx_in,
  output wire logic [1:0] tx_out,
  output wire logic [1:0] request_to_send_n,
  output wire logic [1:0] multi_function_out_n,
  // General purpose inputs of channel B.
  input wire logic carrier_detect_b_n,
  input wire logic ring_indicator_b_n
);
  localparam int LW = $clog2(DEPTH) + 1;

  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic rd_act_q;
  logic wr_act_q;
  logic rd_p1_q;
  logic rd_ch_q;
  logic [2:0] rd_a_q;
  logic wr_ch_q;
  logic [2:0] wr_a_q;
  logic [7:0] wr_d_q;
  wire logic [7:0] rdv [DUC_CHANNELS];
  wire logic [1:0] both_sel;

  // Strobes and lines come from outside the clock domain and pass two flip-flops first.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= {cs_n, channel_select, addr, read_strobe_n, write_strobe_n, data_in, rx_in,
               carrier_detect_b_n, ring_indicator_b_n};
      s2_q <= s1_q;
    end
  end

  wire logic cs_s = s2_q[18];
  wire logic ch_s = ~s2_q[17];
  wire logic [2:0] a_s = s2_q[16:14];
  wire logic rd_s = s2_q[13];
  wire logic wr_s = s2_q[12];
  wire logic [7:0] d_s = s2_q[11:4];
  wire logic [1:0] rx_s = s2_q[3:2];
  wire logic cd_s = s2_q[1];
  wire logic ri_s = s2_q[0];

  // No bus clock exists, so each cycle is recognised from the chip select and strobe levels alone.
  wire logic rd_act = ~cs_s & ~rd_s;
  wire logic wr_act = ~cs_s & ~wr_s;
  wire logic rd_go = rd_act & ~rd_act_q;
  wire logic wr_go = wr_act_q & ~wr_act;
  wire logic both_w = both_sel[wr_ch_q];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      rd_p1_q <= 1'b0;
      rd_ch_q <= 1'b0;
      rd_a_q <= '0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      rd_p1_q <= rd_go;
      if (rd_go) begin
        rd_ch_q <= ch_s;
        rd_a_q <= a_s;
      end
    end
  end

  // Write address and data are held while the strobe is low and used when it rises.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ch_q <= 1'b0;
      wr_a_q <= '0;
      wr_d_q <= '0;
    end else if (wr_act) begin
      wr_ch_q <= ch_s;
      wr_a_q <= a_s;
      wr_d_q <= d_s;
    end
  end

  // The old value stays off the bus until the fresh read value is latched.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      if (rd_p1_q) begin
        data_out <= rdv[rd_ch_q];
      end
      if (!rd_act) begin
        data_oe_n <= 1'b1;
      end else if (rd_p1_q) begin
        data_oe_n <= 1'b0;
      end
    end
  end

  for (genvar c = 0; c < DUC_CHANNELS; c++) begin : g_ch
    logic [DIV_W-1:0] div_q;
    logic [7:0] trig_q;
    logic [7:0] fctl_q;
    logic [7:0] modem_q;
    logic [7:0] alt_q;
    logic [7:0] feat_q;
    logic [1:0] pre_q;
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;
    logic receive_ready_n_n_q;
    logic mf_n_q;
    logic rts_n_q;
    logic to_q;
    logic [9:0] idle_q;
    logic [7:0] rv;
    logic tx_line;
    logic tx_busy;
    logic rx_done;
    duc_fifo_if #(.W(8), .LW(LW)) txf ();
    duc_fifo_if #(.W(8), .LW(LW)) rxf ();

    wire logic wr_here = wr_go & ((wr_ch_q == 1'(c)) | both_w);
    wire logic wr_fctl = wr_here & (wr_a_q == REG_FCTL);
    wire logic gp_cd = (c == 1) ? ~cd_s : 1'b0;
    wire logic gp_ri = (c == 1) ? ~ri_s : 1'b0;
    wire logic at_trig = ~rxf.empty & (8'(rxf.level) >= trig_q);
    wire logic [9:0] to_lim = 10'(TIMEOUT_BITS * duc_os(fctl_q[FCTL_OS8]));
    wire logic pre_end = fctl_q[FCTL_PRESC4] ? (pre_q == 2'h3) : 1'b1;
    wire logic div_end = (cnt_q >= div_q - 1'b1) | (div_q == '0);
    wire logic baud_hi = (cnt_q >= (div_q >> 1));

    assign both_sel[c] = alt_q[ALT_BOTH];
    assign txf.push = wr_here & (wr_a_q == REG_DATA);
    assign txf.wdata = wr_d_q;
    assign rxf.pop = rd_go & (ch_s == 1'(c)) & (a_s == REG_DATA);
    assign rdv[c] = rv;
    assign tx_out[c] = tx_line;
    assign request_to_send_n[c] = rts_n_q;
    assign multi_function_out_n[c] = mf_n_q;

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        div_q <= DIV_W'(DIV_RST);
        trig_q <= TRIG_RST;
        fctl_q <= FCTL_RST;
        modem_q <= MODEM_RST;
        alt_q <= ALT_RST;
        feat_q <= FEAT_RST;
      end else if (wr_here) begin
        unique case (wr_a_q)
          REG_DIV: div_q <= wr_d_q[DIV_W-1:0];
          REG_TRIG: trig_q <= wr_d_q;
          REG_FCTL: fctl_q <= wr_d_q & FCTL_KEEP;
          REG_MODEM: modem_q <= wr_d_q;
          REG_ALT: alt_q <= wr_d_q;
          REG_FEAT: feat_q <= wr_d_q;
          default: ;
        endcase
      end
    end

    // Sampling clock: prescaler of 1 or 4, then the divisor; a divisor of 0 acts as 1.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pre_q <= '0;
        cnt_q <= '0;
        tick_q <= 1'b0;
      end else begin
        pre_q <= pre_end ? 2'h0 : pre_q + 2'h1;
        if (pre_end) begin
          cnt_q <= div_end ? '0 : cnt_q + 1'b1;
        end
        tick_q <= pre_end & div_end;
      end
    end

    // Idle time counted in sampling clocks; four frames of silence mark a time-out.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        idle_q <= '0;
        to_q <= 1'b0;
      end else if (rxf.empty || rx_done || rxf.pop) begin
        idle_q <= '0;
        to_q <= 1'b0;
      end else if (tick_q && !to_q) begin
        idle_q <= idle_q + 10'h001;
        to_q <= (idle_q == to_lim - 10'h001);
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        receive_ready_n_n_q <= 1'b1;
      end else if (!fctl_q[FCTL_FIFO_EN] || !fctl_q[FCTL_BLOCK]) begin
        receive_ready_n_n_q <= rxf.empty;
      end else if (rxf.empty) begin
        receive_ready_n_n_q <= 1'b1;
      end else if (at_trig || to_q) begin
        receive_ready_n_n_q <= 1'b0;
      end
    end

    // The baud clock needs a divisor of at least two to toggle on the pin, whatever the prescaler.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mf_n_q <= 1'b1;
      end else begin
        unique case (duc_mf_t'(alt_q[ALT_MF_HI:ALT_MF_LO]))
          MF_BAUD: mf_n_q <= baud_hi;
          MF_RECEIVE_READY_N: mf_n_q <= receive_ready_n_n_q;
          MF_FLAG, MF_SPARE: mf_n_q <= ~modem_q[MODEM_FLAG];
        endcase
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        rts_n_q <= 1'b1;
      end else if (!feat_q[FEAT_AUTO_DIR]) begin
        rts_n_q <= ~modem_q[MODEM_RTS];
      end else if (txf.push) begin
        rts_n_q <= 1'b0;
      end else if (txf.empty && !tx_busy) begin
        rts_n_q <= 1'b1;
      end
    end

    // Carrier and ring only reach the status byte.
    always_comb begin
      rv = '0;
      unique case (rd_a_q)
        REG_DATA: rv = rxf.rdata;
        REG_DIV: rv[DIV_W-1:0] = div_q;
        REG_TRIG: rv = 8'(rxf.level);
        REG_FCTL: rv = fctl_q;
        REG_MODEM: rv = modem_q;
        REG_STAT: rv = {2'h0, gp_ri, gp_cd, ~tx_busy & txf.empty, ~txf.full, at_trig, ~rxf.empty};
        REG_ALT: rv = alt_q;
        REG_FEAT: rv = 8'(txf.level);
      endcase
    end

    duc_fifo #(.W(8), .DEPTH(DEPTH), .LW(LW)) u_txq (
      .mclk(mclk),
      .rst_n(rst_n),
      .clr(wr_fctl & wr_d_q[FCTL_TX_CLR]),
      .one_deep(~fctl_q[FCTL_FIFO_EN]),
      .q(txf)
    );

    duc_fifo #(.W(8), .DEPTH(DEPTH), .LW(LW)) u_rxq (
      .mclk(mclk),
      .rst_n(rst_n),
      .clr(wr_fctl & wr_d_q[FCTL_RX_CLR]),
      .one_deep(~fctl_q[FCTL_FIFO_EN]),
      .q(rxf)
    );

    duc_serial u_serial (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(tick_q),
      .os8(fctl_q[FCTL_OS8]),
      .rx_s(rx_s[c]),
      .tx_q(tx_line),
      .txf(txf),
      .rxf(rxf),
      .tx_busy(tx_busy),
      .rx_done(rx_done)
    );
  end
endmodule : duc_top
`default_nettype wire

//--- shared/duc_pkg.sv
// Constants, field positions and state types shared by the dual serial channel block.
package duc_pkg;
  localparam int DUC_CHANNELS = 2;
  localparam int DUC_FIFO_DEPTH = 64;
  localparam int DUC_DIV_W = 8;
  localparam int FRAME_BITS = 10;
  localparam int TIMEOUT_BITS = 40;
  localparam int SYNC_W = 19;
  // Timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register locations within one channel.
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_DIV = 3'h1;
  localparam logic [2:0] REG_TRIG = 3'h2;
  localparam logic [2:0] REG_FCTL = 3'h3;
  localparam logic [2:0] REG_MODEM = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;
  localparam logic [2:0] REG_ALT = 3'h6;
  localparam logic [2:0] REG_FEAT = 3'h7;
  // Field positions.
  localparam int FCTL_FIFO_EN = 0;
  localparam int FCTL_BLOCK = 1;
  localparam int FCTL_PRESC4 = 2;
  localparam int FCTL_OS8 = 3;
  localparam int FCTL_RX_CLR = 4;
  localparam int FCTL_TX_CLR = 5;
  localparam int MODEM_RTS = 1;
  localparam int MODEM_FLAG = 3;
  localparam int ALT_BOTH = 0;
  localparam int ALT_MF_LO = 1;
  localparam int ALT_MF_HI = 2;
  localparam int FEAT_AUTO_DIR = 3;
  // Reset values and the FIFO control write mask.
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [7:0] TRIG_RST = 8'h01;
  localparam logic [7:0] FCTL_RST = 8'h00;
  localparam logic [7:0] FCTL_KEEP = 8'h0F;
  localparam logic [7:0] MODEM_RST = 8'h00;
  localparam logic [7:0] ALT_RST = 8'h00;
  localparam logic [7:0] FEAT_RST = 8'h00;
  // Sampling rates.
  localparam logic [4:0] OS16 = 5'h10;
  localparam logic [4:0] OS8 = 5'h08;

  typedef enum logic [1:0] {
    MF_FLAG = 2'h0,
    MF_BAUD = 2'h1,
    MF_RECEIVE_READY_N = 2'h2,
    MF_SPARE = 2'h3
  } duc_mf_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_LOAD = 3'h2,
    TX_SHIFT = 3'h4
  } duc_tx_st_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } duc_rx_st_t;

  function automatic logic [4:0] duc_os(input logic os8);
    return os8 ? OS8 : OS16;
  endfunction : duc_os
endpackage : duc_pkg

//--- shared/duc_fifo_if.sv
// Byte queue handshake between a queue and its filling and draining users.
`timescale 1ns/10ps
`default_nettype none
interface duc_fifo_if #(parameter int W = 8, parameter int LW = 7);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  logic [LW-1:0] level;
  modport store (input push, wdata, pop, output rdata, full, empty, level);
  modport fill (output push, wdata, input full, level);
  modport drain (output pop, input rdata, empty, level);
endinterface : duc_fifo_if
`default_nettype wire

//--- hdl/duc_fifo.sv
// Byte queue with registered read data and a fill counter.
`timescale 1ns/10ps
`default_nettype none
module duc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Control.
  input wire logic clr,
  input wire logic one_deep,
  // Queue.
  duc_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [LW-1:0] lvl_q;
  logic [W-1:0] rd_q;
  wire logic do_push = q.push & ~q.full;
  wire logic do_pop = q.pop & ~q.empty;

  // DEPTH must be a power of two so the pointers wrap by themselves.
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wp_q] <= q.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
    end else if (clr) begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(do_push);
      rp_q <= rp_q + AW'(do_pop);
      lvl_q <= lvl_q + LW'(do_push) - LW'(do_pop);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (do_pop) begin
      rd_q <= mem[rp_q];
    end
  end

  assign q.rdata = rd_q;
  assign q.level = lvl_q;
  assign q.empty = (lvl_q == '0);
  assign q.full = one_deep ? (lvl_q != '0) : (lvl_q == LW'(DEPTH));
endmodule : duc_fifo
`default_nettype wire

//--- hdl/duc_serial.sv
// Serial transmitter and receiver of one channel, eight data bits and one stop bit.
`timescale 1ns/10ps
`default_nettype none
module duc_serial
  import duc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Sampling clock.
  input wire logic tick,
  input wire logic os8,
  // Line.
  input wire logic rx_s,
  output logic tx_q,
  // Queues.
  duc_fifo_if.drain txf,
  duc_fifo_if.fill rxf,
  // State.
  output logic tx_busy,
  output logic rx_done
);
  duc_tx_st_t tx_st_q;
  duc_rx_st_t rx_st_q;
  logic [4:0] tcnt_q;
  logic [4:0] rcnt_q;
  logic [3:0] tbit_q;
  logic [2:0] rbit_q;
  logic [8:0] tsh_q;
  logic [7:0] rsh_q;
  wire logic [4:0] os = duc_os(os8);
  wire logic [4:0] os_last = os - 5'h01;

  assign txf.pop = (tx_st_q == TX_IDLE) & ~txf.empty;
  assign tx_busy = (tx_st_q != TX_IDLE);
  assign rxf.push = rx_done;
  assign rxf.wdata = rsh_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= TX_IDLE;
      tx_q <= 1'b1;
      tcnt_q <= '0;
      tbit_q <= '0;
      tsh_q <= '1;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          if (!txf.empty) begin
            tx_st_q <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tsh_q <= {1'b1, txf.rdata};
          tx_q <= 1'b0;
          tcnt_q <= '0;
          tbit_q <= '0;
          tx_st_q <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tick) begin
            tcnt_q <= (tcnt_q == os_last) ? 5'h00 : tcnt_q + 5'h01;
            if (tcnt_q == os_last) begin
              tx_q <= tsh_q[0];
              tsh_q <= {1'b1, tsh_q[8:1]};
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q == 4'(FRAME_BITS - 1)) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // A start edge is confirmed at mid bit, so glitches shorter than half a bit are dropped.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE;
      rcnt_q <= '0;
      rbit_q <= '0;
      rsh_q <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      unique case (rx_st_q)
        RX_IDLE: begin
          if (tick && !rx_s) begin
            rcnt_q <= 5'h01;
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rcnt_q <= rcnt_q + 5'h01;
            if (rcnt_q == (os >> 1)) begin
              rcnt_q <= '0;
              rbit_q <= '0;
              rx_st_q <= rx_s ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rcnt_q <= (rcnt_q == os_last) ? 5'h00 : rcnt_q + 5'h01;
            if (rcnt_q == os_last) begin
              rsh_q <= {rx_s, rsh_q[7:1]};
              rbit_q <= rbit_q + 3'h1;
              if (rbit_q == 3'h7) begin
                rx_st_q <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rcnt_q <= (rcnt_q == os_last) ? 5'h00 : rcnt_q + 5'h01;
            if (rcnt_q == os_last) begin
              rx_done <= rx_s;
              rx_st_q <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : duc_serial
`default_nettype wire

//--- verification/duc_host_model.sv
// Host processor model that drives the asynchronous register bus.
`timescale 1ns/10ps
`default_nettype none
module duc_host_model (
  // Clock.
  input wire logic mclk,
  // Bus.
  output logic cs_n,
  output logic channel_select,
  output logic [2:0] addr,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  initial begin
    cs_n = 1'b1;
    channel_select = 1'b1;
    addr = 3'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = 8'h00;
  end
  // The write strobe stays low five cycles, since the block samples it through two flops.
  task automatic wr(input logic b, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    cs_n <= 1'b0;
    channel_select <= ~b;
    addr <= a;
    data_in <= d;
    write_strobe_n <= 1'b0;
    repeat (5) @(posedge mclk);
    cs_n <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : wr
  task automatic rd(input logic b, input logic [2:0] a, output logic [7:0] d);
    int i;
    @(posedge mclk);
    cs_n <= 1'b0;
    channel_select <= ~b;
    addr <= a;
    read_strobe_n <= 1'b0;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (data_oe_n !== 1'b0 && i < 12);
    d = (data_oe_n === 1'b0) ? data_out : 8'hXX;
    cs_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : rd
endmodule : duc_host_model
`default_nettype wire

//--- verification/duc_checker.sv
// Port-level assertions for the dual serial channel block.
`timescale 1ns/10ps
`default_nettype none
module duc_checker (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Bus.
  input wire logic cs_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // Lines.
  input wire logic [1:0] tx_out,
  input wire logic [1:0] request_to_send_n,
  input wire logic [1:0] multi_function_out_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_reset_pins: assert property (
    $rose(rst_n) |-> tx_out == 2'h3 && request_to_send_n == 2'h3 && multi_function_out_n == 2'h3)
    else $error("Serial pins not at defaults after reset.");
  chk_reset_bus: assert property (
    $rose(rst_n) |-> data_oe_n && data_out == 8'h00) else $error("Bus not at defaults after reset.");
  chk_read_answer: assert property (
    $fell(read_strobe_n) && !cs_n |-> ##[1:6] !data_oe_n) else $error("Read got no answer.");
  chk_oe_release: assert property (
    $rose(read_strobe_n) |-> ##[1:4] data_oe_n) else $error("Data bus not released.");
  chk_oe_idle: assert property (
    read_strobe_n [*5] |-> data_oe_n) else $error("Data bus driven without a read.");
  chk_oe_deselect: assert property (
    cs_n [*5] |-> data_oe_n) else $error("Data bus driven while deselected.");
  chk_data_hold: assert property (
    read_strobe_n [*5] |=> $stable(data_out)) else $error("Read data changed without a read.");
  // Eight cycles is the shortest bit: 8x sampling at the fastest tick.
  chk_start_bit: assert property (
    $fell(tx_out[0]) |-> !tx_out[0] [*8]) else $error("Start bit too short.");
endmodule : duc_checker
bind duc_top duc_checker duc_checker_inst (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n),
  .read_strobe_n(read_strobe_n), .data_out(data_out), .data_oe_n(data_oe_n), .tx_out(tx_out),
  .request_to_send_n(request_to_send_n), .multi_function_out_n(multi_function_out_n));
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the dual serial channel block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import duc_pkg::*;
  logic mclk, rst_n, cs_n, channel_select, read_strobe_n, write_strobe_n, data_oe_n, rts_s;
  logic carrier_detect_b_n, ring_indicator_b_n;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, rd_v;
  logic [1:0] rx_in, tx_out, request_to_send_n, multi_function_out_n;
  int n_fail, num_checks, cyc;
  duc_host_model duc_host_model_inst (.mclk(mclk), .cs_n(cs_n), .channel_select(channel_select),
    .addr(addr), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n));
  duc_top duc_top_inst (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .channel_select(channel_select),
    .addr(addr), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .rx_in(rx_in), .tx_out(tx_out),
    .request_to_send_n(request_to_send_n), .multi_function_out_n(multi_function_out_n),
    .carrier_detect_b_n(carrier_detect_b_n), .ring_indicator_b_n(ring_indicator_b_n));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // The far side crosses the lines, so channel A feeds channel B's receiver.
  always @(posedge mclk) rx_in <= {tx_out[0], tx_out[1]};
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic b, input logic [2:0] a, input logic [7:0] d);
    duc_host_model_inst.wr(b, a, d);
  endtask : wr
  task automatic chk_rd(input logic b, input logic [2:0] a, input logic [7:0] exp);
    duc_host_model_inst.rd(b, a, rd_v);
    chk(rd_v, exp);
  endtask : chk_rd
  // Order of bits: multi-function pins, request-to-send pins, transmit lines.
  task automatic pins(input logic [5:0] e);
    @(negedge mclk);
    chk({2'h0, multi_function_out_n, request_to_send_n, tx_out}, {2'h0, e});
  endtask : pins
  task automatic until_mf(input logic v, inout int c);
    for (int k = 0; k < 80 && multi_function_out_n[0] !== v; k++) begin
      @(posedge mclk);
      c++;
    end
  endtask : until_mf
  task automatic period(input int exp);
    int c;
    c = 0;
    until_mf(1'b0, c);
    until_mf(1'b1, c);
    c = 0;
    until_mf(1'b0, c);
    until_mf(1'b1, c);
    chk(8'(c), 8'(exp));
  endtask : period
  // Bytes sent here have bit 0 set, so the low run is the start bit alone.
  task automatic send(input logic [7:0] d, input int len);
    int c;
    wr(1'b0, REG_DATA, d);
    for (int k = 0; k < 60 && tx_out[0] !== 1'b0; k++) @(posedge mclk);
    rts_s = request_to_send_n[0];
    c = 0;
    while (tx_out[0] === 1'b0 && c < 40) begin
      @(posedge mclk);
      c++;
    end
    chk(8'(c), 8'(len));
    repeat (12 * len) @(posedge mclk);
  endtask : send
  initial begin
    rst_n = 1'b0;
    carrier_detect_b_n = 1'b1;
    ring_indicator_b_n = 1'b1;
    rx_in = 2'h3;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    pins(6'h3F);
    chk_rd(1'b0, REG_STAT, 8'h0C);
    wr(1'b0, REG_DIV, 8'h03);
    chk_rd(1'b0, REG_DIV, 8'h03);
    chk_rd(1'b1, REG_DIV, DIV_RST);
    // Alternate bit 0 of the addressed channel makes one write land in both channels.
    wr(1'b0, REG_ALT, 8'h01);
    wr(1'b0, REG_DIV, 8'h07);
    chk_rd(1'b1, REG_DIV, 8'h07);
    chk_rd(1'b0, REG_DIV, 8'h07);
    wr(1'b0, REG_ALT, ALT_RST);
    wr(1'b1, REG_DIV, DIV_RST);
    chk_rd(1'b1, REG_ALT, ALT_RST);
    wr(1'b1, REG_STAT, 8'hFF);
    @(posedge mclk);
    carrier_detect_b_n <= 1'b0;
    ring_indicator_b_n <= 1'b0;
    chk_rd(1'b1, REG_STAT, 8'h3C);
    chk_rd(1'b0, REG_STAT, 8'h0C);
    pins(6'h3F);
    wr(1'b0, REG_DIV, DIV_RST);
    wr(1'b0, REG_MODEM, 8'h08);
    pins(6'h2F);
    wr(1'b0, REG_MODEM, 8'h00);
    pins(6'h3F);
    wr(1'b0, REG_ALT, 8'h02);
    wr(1'b0, REG_DIV, 8'h04);
    period(4);
    wr(1'b0, REG_FCTL, 8'h04);
    period(16);
    wr(1'b0, REG_FCTL, FCTL_RST);
    wr(1'b0, REG_DIV, DIV_RST);
    wr(1'b0, REG_ALT, ALT_RST);
    wr(1'b1, REG_ALT, 8'h04);
    pins(6'h3F);
    send(8'h55, 16);
    pins(6'h1F);
    chk_rd(1'b1, REG_DATA, 8'h55);
    pins(6'h3F);
    wr(1'b0, REG_FCTL, 8'h08);
    wr(1'b1, REG_FCTL, 8'h08);
    send(8'hA5, 8);
    chk_rd(1'b1, REG_DATA, 8'hA5);
    wr(1'b0, REG_FCTL, 8'h00);
    wr(1'b1, REG_FCTL, 8'h03);
    wr(1'b1, REG_TRIG, 8'h02);
    send(8'h33, 16);
    pins(6'h3F);
    chk_rd(1'b1, REG_TRIG, 8'h01);
    send(8'h0F, 16);
    pins(6'h1F);
    chk_rd(1'b1, REG_DATA, 8'h33);
    pins(6'h1F);
    chk_rd(1'b1, REG_DATA, 8'h0F);
    pins(6'h3F);
    // One byte stays below the trigger, so only forty idle bit times can pull the pin low.
    send(8'h11, 16);
    pins(6'h3F);
    repeat (700) @(posedge mclk);
    pins(6'h1F);
    chk_rd(1'b1, REG_DATA, 8'h11);
    pins(6'h3F);
    wr(1'b0, REG_MODEM, 8'h02);
    pins(6'h3B);
    wr(1'b0, REG_FEAT, 8'h08);
    pins(6'h3F);
    send(8'h55, 16);
    chk({7'h00, rts_s}, 8'h00);
    pins(6'h3F);
    wr(1'b0, REG_MODEM, 8'h08);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    pins(6'h3F);
    chk_rd(1'b0, REG_MODEM, MODEM_RST);
    final_report();
  end
endmodule : tb
`default_nettype wire
